// >>> bench/remote_master.sv
`timescale 1ns/100ps

// Remote bus master: 64 ns per bit, waiting while the slave stretches SCL.
module remote_master (
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  int stuck = 0;

  initial begin
    scl_low = 1'h0;
    sda_low = 1'h0;
  end

  // Pin changes sit on the falling clock edge, so the slave's synchroniser never races them.
  task automatic align;
    if ($time % 8 != 0) #4;
  endtask : align

  // The wait is bounded so that a slave that never lets go shows up as a count.
  task automatic rise;
    int n;
    scl_low = 1'h0;
    #8;
    n = 0;
    while (scl !== 1'h1 && n < 20000) begin
      #8;
      n++;
    end
    if (n >= 20000) stuck++;
    #16;
  endtask : rise

  task automatic put_bit(input logic b, output logic s);
    align();
    sda_low = !b;
    #32;
    rise();
    s = sda;
    #8;
    scl_low = 1'h1;
  endtask : put_bit

  task automatic start_cond;
    align();
    sda_low = 1'h0;
    #32;
    rise();
    sda_low = 1'h1;
    #16;
    scl_low = 1'h1;
  endtask : start_cond

  task automatic stop_cond;
    align();
    sda_low = 1'h1;
    #32;
    rise();
    sda_low = 1'h0;
    #32;
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'h1, s);
    ack = !s;
  endtask : send_byte
endmodule : remote_master

// >>> bench/testbench.sv
`timescale 1ns/100ps
`include "i2c_slave_defs.svh"

module testbench;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, scl_o, scl_oe, sda_o, sda_oe, irq, scl_low, sda_low;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  wire scl = ~scl_low & ~(scl_oe & ~scl_o);
  wire sda = ~sda_low & ~(sda_oe & ~sda_o);
  int fails = 0, checks_done = 0;

  always #4 clk = ~clk;

  i2c_slave_rx i_i2c_slave_rx (.CLK(clk), .RESET(reset), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .SCL_I(scl), .SCL_O(scl_o),
    .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .IRQ(irq));

  remote_master i_remote_master (.scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic timeout;
    fails++;
    $display("Error at %0t: wait ran out", $time);
    stop_test();
  endtask : timeout

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    n = 0;
    while (n < 100) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid === 1'h1) break;
      n++;
    end
    if (n >= 100) timeout();
    bready <= 1'h0;
    check({30'h0, bresp}, {30'h0, exp_resp});
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    n = 0;
    while (n < 100) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
      n++;
    end
    if (n >= 100) timeout();
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(d, exp);
  endtask : rc

  // Software polls the flag; the serial side runs on its own timing meanwhile.
  task automatic wait_done;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    rd(`REG_CTRL, d, r);
    while (d[0] !== 1'h1 && n < 1000) begin
      rd(`REG_CTRL, d, r);
      n++;
    end
    if (n >= 1000) timeout();
  endtask : wait_done

  task automatic byte_ack(input logic [7:0] b, input logic exp);
    logic a;
    i_remote_master.send_byte(b, a);
    check({31'h0, a}, {31'h0, exp});
  endtask : byte_ack

  task automatic own_xfer;
    i_remote_master.start_cond();
    byte_ack(8'ha4, 1'h1);
    wait_done();
    rc(`REG_STATUS, 32'h60);
    wr(`REG_CTRL, 32'h3, 2'h0);
    i_remote_master.stop_cond();
    wait_done();
    rc(`REG_STATUS, 32'ha0);
  endtask : own_xfer

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic s;
    repeat (20) @(posedge clk);
    reset <= 1'h0;
    rc(`REG_STATUS, 32'hf8);
    rc(`REG_OWN_ADDR, 32'hfe);
    rc(`REG_CTRL, 32'h0);
    rc(`REG_INT_MASK, 32'h0);
    rd(8'h18, d, r);
    check({30'h0, r}, 32'h2);
    wr(8'h18, 32'hff, 2'h2);
    wr(`REG_OWN_ADDR, 32'ha5, 2'h0);
    wr(`REG_INT_MASK, 32'h1, 2'h0);
    wr(`REG_CTRL, 32'h2, 2'h0);
    i_remote_master.start_cond();
    byte_ack(8'h00, 1'h1);
    wait_done();
    rc(`REG_STATUS, 32'h70);
    check({31'h0, irq}, 32'h1);
    wr(`REG_INT_STAT, 32'h1, 2'h0);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    wr(`REG_CTRL, 32'h3, 2'h0);
    byte_ack(8'h5a, 1'h1);
    wait_done();
    rc(`REG_STATUS, 32'h90);
    rc(`REG_DATA, 32'h5a);
    wr(`REG_CTRL, 32'h1, 2'h0);
    byte_ack(8'hc3, 1'h0);
    wait_done();
    rc(`REG_STATUS, 32'h98);
    rc(`REG_DATA, 32'hc3);
    rc(`REG_STATUS, 32'h98);
    wr(`REG_CTRL, 32'h1, 2'h0);
    rc(`REG_STATUS, 32'hf8);
    i_remote_master.stop_cond();
    i_remote_master.start_cond();
    byte_ack(8'ha4, 1'h0);
    i_remote_master.stop_cond();
    rc(`REG_STATUS, 32'hf8);
    wr(`REG_CTRL, 32'h2, 2'h0);
    own_xfer();
    wr(`REG_OWN_ADDR, 32'ha4, 2'h0);
    wr(`REG_CTRL, 32'h3, 2'h0);
    i_remote_master.start_cond();
    byte_ack(8'h00, 1'h0);
    i_remote_master.stop_cond();
    own_xfer();
    wr(`REG_CTRL, 32'h3, 2'h0);
    wr(`REG_INT_STAT, 32'h3, 2'h0);
    wr(`REG_INT_MASK, 32'h3, 2'h0);
    i_remote_master.start_cond();
    for (int i = 0; i < 3; i++) i_remote_master.put_bit(1'h1, s);
    i_remote_master.start_cond();
    wait_done();
    rc(`REG_STATUS, 32'h00);
    rc(`REG_INT_STAT, 32'h3);
    check({31'h0, irq}, 32'h1);
    check({30'h0, scl_oe, sda_oe}, 32'h0);
    wr(`REG_CTRL, 32'hb, 2'h0);
    repeat (3) @(posedge clk);
    rc(`REG_CTRL, 32'h2);
    rc(`REG_STATUS, 32'hf8);
    check({30'h0, scl_oe, sda_oe}, 32'h0);
    i_remote_master.stop_cond();
    own_xfer();
    wr(`REG_CTRL, 32'h7, 2'h0);
    wait_done();
    rc(`REG_STATUS, 32'h08);
    check({30'h0, scl, sda}, 32'h0);
    wr(`REG_CTRL, 32'h3, 2'h0);
    repeat (4) @(posedge clk);
    check({30'h0, scl, sda}, 32'h3);
    rc(`REG_CTRL, 32'h2);
    check(i_remote_master.stuck, 32'h0);
    stop_test();
  end
endmodule : testbench

// >>> core/i2c_slave_defs.svh
`ifndef I2C_SLAVE_DEFS_SVH
`define I2C_SLAVE_DEFS_SVH

// Register byte offsets on the AXI4-Lite port.
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_DATA 8'h08
`define REG_OWN_ADDR 8'h0c
`define REG_INT_STAT 8'h10
`define REG_INT_MASK 8'h14

// Control register bit positions.
`define CTRL_OP_DONE_BIT 0
`define CTRL_ACK_EN_BIT 1
`define CTRL_START_BIT 2
`define CTRL_STOP_BIT 3

// Interrupt status and mask bit positions.
`define INT_OP_DONE_BIT 0
`define INT_BUS_ERR_BIT 1

// Reset values.
`define OWN_ADDR_RST 8'hfe
`define CTRL_RST 3'h0
`define INT_RST 2'h0

// Status codes.
`define ST_START_DONE 8'h08
`define ST_OWN_ACK 8'h60
`define ST_GC_ACK 8'h70
`define ST_OWN_DATA_ACK 8'h80
`define ST_OWN_DATA_NACK 8'h88
`define ST_GC_DATA_ACK 8'h90
`define ST_GC_DATA_NACK 8'h98
`define ST_STOP_RESTART 8'ha0
`define ST_NO_INFO 8'hf8
`define ST_BUS_ERROR 8'h00

// Frame and bus constants.
`define BYTE_BITS 4'h8
`define GC_ADDRESS 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Timing: hold time of a generated START, rounded up to whole cycles.
`define CLK_PERIOD_NS 8
`define T_START_HOLD_NS 4000
`define START_HOLD_CYC ((`T_START_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> core/i2c_slave_pkg.sv
package i2c_slave_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ADDR_ACK = 4'b0010,
    ST_DATA = 4'b0011,
    ST_DATA_ACK = 4'b0100,
    ST_HOLD = 4'b0101,
    ST_SKIP = 4'b0110,
    ST_ERR = 4'b0111,
    ST_START_GEN = 4'b1000
  } state_t;

  typedef struct packed {
    logic stop_request;
    logic start_request;
    logic ack_enable;
  } ctrl_t;

  typedef struct packed {
    logic [6:0] own;
    logic general_call_enable;
  } own_addr_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } line_t;

endpackage : i2c_slave_pkg

// >>> core/i2c_slave_rx.sv
`timescale 1ns/100ps
`include "i2c_slave_defs.svh"

module i2c_slave_rx import i2c_slave_pkg::*; (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  output logic IRQ
);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  line_t scl;
  line_t sda;
  state_t state_q;
  ctrl_t ctrl_q;
  own_addr_t own_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] data_q;
  logic [7:0] stat_q;
  logic [9:0] hold_q;
  logic sda_oe_q, scl_oe_q, pin_lo_q;
  logic gc_q, nack_q, gen_q, busy_q, start_pend_q, op_done_q;
  logic op_set_q, berr_set_q, rec_q, gen_rel_q;
  logic [1:0] int_stat_q, int_mask_q;
  logic irq_q;
  logic aw_got_q, w_got_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] rdata_q;
  logic start_ev, stop_ev, in_frame, own_match, gc_match;
  logic wr_fire, clr_ev;
  logic rd_ok;
  logic [7:0] rd_byte;

  line_sync u_scl_sync (
    .clk(CLK),
    .reset(RESET),
    .pin(SCL_I),
    .line(scl)
  );

  line_sync u_sda_sync (
    .clk(CLK),
    .reset(RESET),
    .pin(SDA_I),
    .line(sda)
  );

  assign start_ev = sda.fall & scl.level;
  assign stop_ev = sda.rise & scl.level;
  // A STOP or repeated START lands in the first bit slot of a byte, so only later slots are inside the frame.
  assign in_frame = ((state_q == ST_ADDR || state_q == ST_DATA) && bit_q > 4'h1) ||
                    state_q == ST_ADDR_ACK || state_q == ST_DATA_ACK;
  // An address is only recognised while ack_enable is set.
  assign own_match = ctrl_q.ack_enable && shift_q == {own_q.own, 1'b0};
  assign gc_match = ctrl_q.ack_enable && own_q.general_call_enable && shift_q == `GC_ADDRESS;

  // Frame tracking, acknowledge, clock stretching and START generation.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      stat_q <= `ST_NO_INFO;
      hold_q <= 10'h000;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      gc_q <= 1'b0;
      nack_q <= 1'b0;
      gen_q <= 1'b0;
      op_set_q <= 1'b0;
      berr_set_q <= 1'b0;
      rec_q <= 1'b0;
      gen_rel_q <= 1'b0;
    end else begin
      op_set_q <= 1'b0;
      berr_set_q <= 1'b0;
      rec_q <= 1'b0;
      gen_rel_q <= 1'b0;
      if ((start_ev || stop_ev) && state_q != ST_ERR && state_q != ST_START_GEN && !gen_q) begin
        bit_q <= 4'h0;
        sda_oe_q <= 1'b0;
        scl_oe_q <= 1'b0;
        if (in_frame) begin
          state_q <= ST_ERR;
          berr_set_q <= 1'b1;
          if (!op_done_q) begin
            stat_q <= `ST_BUS_ERROR;
            op_set_q <= 1'b1;
          end
        end else begin
          if (state_q == ST_DATA && !op_done_q) begin
            stat_q <= `ST_STOP_RESTART;
            op_set_q <= 1'b1;
          end
          state_q <= start_ev ? ST_ADDR : ST_IDLE;
        end
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (start_pend_q && !busy_q && !op_done_q) begin
              state_q <= ST_START_GEN;
              sda_oe_q <= 1'b1;
              hold_q <= 10'h000;
              gen_q <= 1'b1;
            end
          end
          ST_ADDR, ST_DATA: begin
            if (scl.rise) begin
              shift_q <= {shift_q[6:0], sda.level};
              bit_q <= bit_q + 4'h1;
            end else if (scl.fall && bit_q == `BYTE_BITS) begin
              bit_q <= 4'h0;
              if (state_q == ST_DATA) begin
                sda_oe_q <= ctrl_q.ack_enable;
                nack_q <= ~ctrl_q.ack_enable;
                state_q <= ST_DATA_ACK;
              end else if ((own_match || gc_match) && !op_done_q) begin
                sda_oe_q <= 1'b1;
                gc_q <= gc_match;
                nack_q <= 1'b0;
                state_q <= ST_ADDR_ACK;
              end else begin
                state_q <= ST_SKIP;
              end
            end
          end
          ST_ADDR_ACK, ST_DATA_ACK: begin
            if (scl.fall) begin
              sda_oe_q <= 1'b0;
              scl_oe_q <= 1'b1;
              state_q <= ST_HOLD;
              if (!op_done_q) begin
                op_set_q <= 1'b1;
                if (state_q == ST_ADDR_ACK) begin
                  stat_q <= gc_q ? `ST_GC_ACK : `ST_OWN_ACK;
                end else if (gc_q) begin
                  stat_q <= nack_q ? `ST_GC_DATA_NACK : `ST_GC_DATA_ACK;
                end else begin
                  stat_q <= nack_q ? `ST_OWN_DATA_NACK : `ST_OWN_DATA_ACK;
                end
              end
            end
          end
          ST_HOLD: begin
            // SCL stays low until software clears the flag, so the master simply waits.
            if (!op_done_q && !op_set_q) begin
              scl_oe_q <= 1'b0;
              sda_oe_q <= 1'b0;
              if (gen_q) begin
                state_q <= ST_IDLE;
                gen_q <= 1'b0;
                gen_rel_q <= 1'b1;
              end else begin
                state_q <= nack_q ? ST_SKIP : ST_DATA;
              end
            end
          end
          ST_ERR: begin
            // Lines are already released; only internal state returns to idle.
            if (!op_done_q && !op_set_q && ctrl_q.stop_request) begin
              state_q <= ST_IDLE;
              rec_q <= 1'b1;
            end
          end
          ST_START_GEN: begin
            hold_q <= hold_q + 10'h001;
            if (hold_q == 10'(`START_HOLD_CYC - 1)) begin
              scl_oe_q <= 1'b1;
              state_q <= ST_HOLD;
              if (!op_done_q) begin
                stat_q <= `ST_START_DONE;
                op_set_q <= 1'b1;
              end
            end
          end
          ST_SKIP: begin
            state_q <= ST_SKIP;
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Received byte is latched when its acknowledge bit ends.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      data_q <= 8'h00;
    end else if (state_q == ST_DATA_ACK && scl.fall && !op_done_q) begin
      data_q <= shift_q;
    end
  end

  // Bus busy tracking for the pending START.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      busy_q <= 1'b0;
    end else if (start_ev) begin
      busy_q <= 1'b1;
    end else if (stop_ev || gen_rel_q || rec_q) begin
      busy_q <= 1'b0;
    end
  end

  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign clr_ev = wr_fire && w_lane_q && aw_addr_q == `REG_CTRL && w_data_q[`CTRL_OP_DONE_BIT] && op_done_q;

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      op_done_q <= 1'b0;
    end else if (op_set_q) begin
      op_done_q <= 1'b1;
    end else if (clr_ev) begin
      op_done_q <= 1'b0;
    end
  end

  // A START is only queued when it is asked for as the end-of-slave status is cleared.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      start_pend_q <= 1'b0;
    end else if (gen_q) begin
      start_pend_q <= 1'b0;
    end else if (clr_ev && w_data_q[`CTRL_START_BIT] &&
                 (stat_q == `ST_GC_DATA_NACK || stat_q == `ST_STOP_RESTART || stat_q == `ST_OWN_DATA_NACK)) begin
      start_pend_q <= 1'b1;
    end
  end

  // Software-written configuration.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl_q <= `CTRL_RST;
      own_q <= `OWN_ADDR_RST;
      int_mask_q <= `INT_RST;
    end else begin
      if (wr_fire && w_lane_q) begin
        case (aw_addr_q)
          `REG_CTRL: begin
            ctrl_q.ack_enable <= w_data_q[`CTRL_ACK_EN_BIT];
            ctrl_q.start_request <= w_data_q[`CTRL_START_BIT];
            ctrl_q.stop_request <= w_data_q[`CTRL_STOP_BIT];
          end
          `REG_OWN_ADDR: own_q <= w_data_q;
          `REG_INT_MASK: int_mask_q <= w_data_q[1:0];
          default: own_q <= own_q;
        endcase
      end
      if (rec_q) begin
        ctrl_q.stop_request <= 1'b0;
      end
      if (gen_rel_q) begin
        ctrl_q.start_request <= 1'b0;
      end
    end
  end

  // Sticky interrupt sources; a new event beats a write-one clear.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      int_stat_q <= `INT_RST;
      irq_q <= 1'b0;
    end else begin
      int_stat_q[`INT_OP_DONE_BIT] <= op_set_q | (int_stat_q[`INT_OP_DONE_BIT] &
        ~(wr_fire && w_lane_q && aw_addr_q == `REG_INT_STAT && w_data_q[`INT_OP_DONE_BIT]));
      int_stat_q[`INT_BUS_ERR_BIT] <= berr_set_q | (int_stat_q[`INT_BUS_ERR_BIT] &
        ~(wr_fire && w_lane_q && aw_addr_q == `REG_INT_STAT && w_data_q[`INT_BUS_ERR_BIT]));
      irq_q <= |(int_stat_q & int_mask_q);
    end
  end

  // AXI4-Lite write channel; only byte lane 0 carries register bits.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      aw_addr_q <= 8'h00;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && awready_q) begin
        aw_got_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
        awready_q <= 1'b0;
      end
      if (S_AXI_WVALID && wready_q) begin
        w_got_q <= 1'b1;
        w_data_q <= S_AXI_WDATA[7:0];
        w_lane_q <= S_AXI_WSTRB[0];
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (aw_addr_q == `REG_CTRL || aw_addr_q == `REG_STATUS || aw_addr_q == `REG_DATA ||
                    aw_addr_q == `REG_OWN_ADDR || aw_addr_q == `REG_INT_STAT ||
                    aw_addr_q == `REG_INT_MASK) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_byte = 8'h00;
    case (S_AXI_ARADDR)
      `REG_CTRL: begin
        rd_byte[`CTRL_OP_DONE_BIT] = op_done_q;
        rd_byte[`CTRL_ACK_EN_BIT] = ctrl_q.ack_enable;
        rd_byte[`CTRL_START_BIT] = ctrl_q.start_request;
        rd_byte[`CTRL_STOP_BIT] = ctrl_q.stop_request;
      end
      `REG_STATUS: rd_byte = op_done_q ? stat_q : `ST_NO_INFO;
      `REG_DATA: rd_byte = data_q;
      `REG_OWN_ADDR: rd_byte = own_q;
      `REG_INT_STAT: rd_byte[1:0] = int_stat_q;
      `REG_INT_MASK: rd_byte[1:0] = int_mask_q;
      default: rd_ok = 1'b0;
    endcase
  end

  // AXI4-Lite read channel; data is captured when the address is taken.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      rresp_q <= `RESP_OKAY;
    end else if (S_AXI_ARVALID && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_byte;
      rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Open-drain pins only ever pull low.
  always_ff @(posedge CLK) begin
    pin_lo_q <= 1'b0;
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = {24'h000000, rdata_q};
  assign S_AXI_RRESP = rresp_q;
  assign SCL_O = pin_lo_q;
  assign SDA_O = pin_lo_q;
  assign SCL_OE = scl_oe_q;
  assign SDA_OE = sda_oe_q;
  assign IRQ = irq_q;

  property p_gc_nack;
    (state_q == ST_DATA_ACK && scl.fall && gc_q && nack_q && !op_done_q) |=>
      (stat_q == `ST_GC_DATA_NACK && data_q == $past(shift_q)) ##1 op_done_q;
  endproperty
  a_gc_nack: assert property (p_gc_nack) else $error("general-call NACK did not report 0x98");

  property p_gc_ack;
    (state_q == ST_DATA_ACK && scl.fall && gc_q && !nack_q && !op_done_q) |=> stat_q == `ST_GC_DATA_ACK;
  endproperty
  a_gc_ack: assert property (p_gc_ack) else $error("general-call ACK did not report 0x90");

  property p_stop_addr;
    (stop_ev && state_q == ST_DATA && bit_q == 4'h1 && !op_done_q) |=>
      stat_q == `ST_STOP_RESTART && state_q == ST_IDLE ##1 op_done_q;
  endproperty
  a_stop_addr: assert property (p_stop_addr) else $error("STOP while addressed did not report 0xA0");

  property p_no_recog;
    (state_q == ST_ADDR && scl.fall && bit_q == `BYTE_BITS && !ctrl_q.ack_enable && !start_ev && !stop_ev) |=>
      state_q == ST_SKIP && !sda_oe_q;
  endproperty
  a_no_recog: assert property (p_no_recog) else $error("address recognised with ack disabled");

  property p_gc_gate;
    (state_q == ST_ADDR && scl.fall && bit_q == `BYTE_BITS && shift_q == `GC_ADDRESS &&
     !own_q.general_call_enable && !start_ev && !stop_ev) |=> state_q == ST_SKIP;
  endproperty
  a_gc_gate: assert property (p_gc_gate) else $error("general call recognised while disabled");

  property p_start_gen;
    (state_q == ST_IDLE && start_pend_q && !busy_q && !op_done_q && !start_ev && !stop_ev) |=>
      state_q == ST_START_GEN ##1 SDA_OE;
  endproperty
  a_start_gen: assert property (p_start_gen) else $error("pending START not issued on free bus");

  property p_idle_code;
    (S_AXI_ARVALID && arready_q && S_AXI_ARADDR == `REG_STATUS && !op_done_q) |=> S_AXI_RDATA[7:0] == `ST_NO_INFO;
  endproperty
  a_idle_code: assert property (p_idle_code) else $error("status not 0xF8 while flag clear");

  property p_bus_err;
    (start_ev && (state_q == ST_ADDR || state_q == ST_DATA) && bit_q > 4'h1 && !op_done_q) |=>
      (state_q == ST_ERR && stat_q == `ST_BUS_ERROR) ##1 (op_done_q && !SDA_OE && !SCL_OE);
  endproperty
  a_bus_err: assert property (p_bus_err) else $error("illegal START not flagged as bus error");

  property p_recover;
    (state_q == ST_ERR && !op_done_q && !op_set_q && ctrl_q.stop_request) |=>
      state_q == ST_IDLE ##1 (!ctrl_q.stop_request && !SDA_OE && !SCL_OE);
  endproperty
  a_recover: assert property (p_recover) else $error("bus-error recovery incomplete");

  property p_stable;
    op_done_q && $past(op_done_q) |-> $stable(stat_q);
  endproperty
  a_stable: assert property (p_stable) else $error("status changed while flag set");

  c_gc_nack: cover property (op_set_q && stat_q == `ST_GC_DATA_NACK);
  c_stop_addr: cover property (op_set_q && stat_q == `ST_STOP_RESTART);
  c_recover: cover property (state_q == ST_ERR ##[1:1000] rec_q);
  c_start_gen: cover property (gen_rel_q);

endmodule : i2c_slave_rx

// >>> core/line_sync.sv
`timescale 1ns/100ps

module line_sync import i2c_slave_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic pin,
  output line_t line
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // The idle bus level is high, so reset to high to avoid a false edge.
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign line.level = sync_q;
  assign line.rise = sync_q & ~last_q;
  assign line.fall = ~sync_q & last_q;

endmodule : line_sync
